// ---- hw/gpei_top.sv ----
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
// Contract
// - An input pin with its interrupt enable at 0 never raises an interrupt, and that is the reset state.
// - With both edge selects at 0, either transition sets the interrupt and a pin-state read clears it.
// - With both edge selects at 0, the interrupt also clears when the input returns to its level at the last read.
// - Rising select only, filter off, sets the interrupt only on a low-to-high transition.
// - Falling select only, filter off, sets the interrupt only on a high-to-low transition.
// - Both selects at 1, filter off, sets the interrupt on either transition.
// - When any edge select of an enabled pin is 1, only a pin-state read or a write of 1 to its bit of the clear register clears the interrupt.
// - Rising-only with filter counts a rise only if the input stays high for more than 1075ns.
// - Falling-only with filter counts a fall only if the input stays low for more than 1075ns.
// - Any-edge modes with filter count a transition only if the new level holds for more than 1075ns.
// - A pin whose direction bit is 0 (output) never raises an interrupt.
// - Direction bit 1 makes a pin an input and 0 an output, all pins inputs after reset.
// - A status register reports per pin which inputs raised an interrupt, bit n for pin n.
// - A pin-state read returns inputs, inverted where polarity bits are 1, and outputs' last written level.
module gpei_top (
  input  wire logic        i_core_clk, // Core clock, 250 MHz.
  input  wire logic        i_rst_n,    // Asynchronous reset, active low.
  input  wire logic [7:0]  i_awaddr,   // Write address.
  input  wire logic        i_awvalid,  // Write address valid.
  output logic             o_awready,  // Write address ready.
  input  wire logic [31:0] i_wdata,    // Write data.
  input  wire logic [3:0]  i_wstrb,    // Write byte strobes.
  input  wire logic        i_wvalid,   // Write data valid.
  output logic             o_wready,   // Write data ready.
  output logic [1:0]       o_bresp,    // Write response.
  output logic             o_bvalid,   // Write response valid.
  input  wire logic        i_bready,   // Write response ready.
  input  wire logic [7:0]  i_araddr,   // Read address.
  input  wire logic        i_arvalid,  // Read address valid.
  output logic             o_arready,  // Read address ready.
  output logic [31:0]      o_rdata,    // Read data.
  output logic [1:0]       o_rresp,    // Read response.
  output logic             o_rvalid,   // Read data valid.
  input  wire logic        i_rready,   // Read data ready.
  input  wire logic [15:0] i_pin,      // Pin input levels.
  output logic [15:0]      o_pin_out,  // Pin output levels.
  output logic [15:0]      o_pin_oe,   // Pin output enables, high while driven.
  output logic             o_irq_n     // Interrupt, active low.
);
  import gpei_pkg::*;

  typedef struct packed {
    logic [15:0] outlvl;
    logic [15:0] pinv;
    logic [15:0] dir;
    logic [15:0] ien;
    logic [15:0] rsel;
    logic [15:0] fsel;
    logic [15:0] fen;
    logic [15:0] mask;
    logic [15:0] status;
    logic [15:0] snap;
    logic [15:0] prev;
    logic        init;
    logic        awrdy;
    logic        wrdy;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        irq_n;
    logic [15:0] pin_out;
    logic [15:0] pin_oe;
  } gpei_state_s;

  gpei_state_s r;
  gpei_state_s n;

  logic [15:0] raw_w;
  logic [15:0] lvl_w;
  logic [15:0] rise_v;
  logic [15:0] fall_v;
  logic [15:0] any_mode_v;
  logic [15:0] active_v;
  logic [15:0] set_v;
  logic [15:0] revert_v;
  logic [15:0] swclr_v;
  logic [15:0] clr_v;
  logic [15:0] state_v;
  logic [15:0] wmerge;
  logic        ar_hs;
  logic        st_rd;
  logic        wr_do;
  gpei_reg_e   rd_sel;
  gpei_reg_e   wr_sel;

  // ==========================================================================
  // Address decoder, shared by the read and the write paths.
  function automatic gpei_reg_e gpei_dec(input logic [7:0] a);
    gpei_reg_e s;
    if (a == GPEI_OFF_STATE) begin
      s = GPEI_REG_STATE;
    end else if (a == GPEI_OFF_OUTLVL) begin
      s = GPEI_REG_OUTLVL;
    end else if (a == GPEI_OFF_PINV) begin
      s = GPEI_REG_PINV;
    end else if (a == GPEI_OFF_DIR) begin
      s = GPEI_REG_DIR;
    end else if (a == GPEI_OFF_IEN) begin
      s = GPEI_REG_IEN;
    end else if (a == GPEI_OFF_STATUS) begin
      s = GPEI_REG_STATUS;
    end else if (a == GPEI_OFF_RISE) begin
      s = GPEI_REG_RISE;
    end else if (a == GPEI_OFF_FALL) begin
      s = GPEI_REG_FALL;
    end else if (a == GPEI_OFF_FILT) begin
      s = GPEI_REG_FILT;
    end else if (a == GPEI_OFF_CLEAR) begin
      s = GPEI_REG_CLEAR;
    end else if (a == GPEI_OFF_MASK) begin
      s = GPEI_REG_MASK;
    end else begin
      s = GPEI_REG_NONE;
    end
    return s;
  endfunction

  // Byte-lane merge of a 16-bit register with write data.
  function automatic logic [15:0] gpei_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [15:0] m;
    m = old;
    if (st[0]) begin
      m[7:0] = wd[7:0];
    end
    if (st[1]) begin
      m[15:8] = wd[15:8];
    end
    return m;
  endfunction

  // ==========================================================================
  // One synchroniser and glitch filter per pin.
  for (genvar k = 0; k < 16; k++) begin : g_pin
    gpei_filter u_filter (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_pin      (i_pin[k]),
      .i_filt_en  (r.fen[k]),
      .o_raw      (raw_w[k]),
      .o_lvl      (lvl_w[k])
    );
  end

  // ==========================================================================
  // Edge detection and interrupt qualification per pin.
  assign rise_v     = {16{r.init}} & lvl_w & ~r.prev;
  assign fall_v     = {16{r.init}} & ~lvl_w & r.prev;
  assign any_mode_v = ~r.rsel & ~r.fsel;
  assign active_v   = r.dir & r.ien;
  // In any-edge mode an edge back to the level of the last read is a revert, not a new event.
  assign set_v      = active_v & ((any_mode_v & (rise_v | fall_v) & (lvl_w ^ r.snap)) |
                                  (r.rsel & rise_v) | (r.fsel & fall_v));
  assign revert_v   = active_v & any_mode_v & ~(lvl_w ^ r.snap) & {16{r.init}};
  assign state_v    = (r.dir & (raw_w ^ r.pinv)) | (~r.dir & r.outlvl);

  // Bus handshakes and decoded selects.
  assign ar_hs  = i_arvalid & r.arrdy;
  assign rd_sel = gpei_dec(i_araddr);
  assign st_rd  = ar_hs && (rd_sel == GPEI_REG_STATE);
  assign wr_do  = !r.awrdy && !r.wrdy && !r.bvalid;
  assign wr_sel = gpei_dec(r.awaddr);
  assign wmerge = gpei_merge(16'h0000, r.wdata, r.wstrb);
  assign swclr_v = (wr_do && wr_sel == GPEI_REG_CLEAR) ? wmerge : 16'h0000;
  assign clr_v  = {16{st_rd}} | revert_v | swclr_v;

  // ==========================================================================
  // Next-state logic: bus slave, configuration registers and interrupt status.
  always_comb begin
    n      = r;
    n.init = 1'b1;
    n.prev = lvl_w;
    if (!r.init) begin
      n.snap = lvl_w;
    end
    if (st_rd) begin
      n.snap = lvl_w;
    end
    // A new event wins over any clear in the same cycle.
    n.status = set_v | (r.status & ~clr_v);
    // Write address and data are taken in either order.
    if (i_awvalid && r.awrdy) begin
      n.awrdy  = 1'b0;
      n.awaddr = i_awaddr;
    end
    if (i_wvalid && r.wrdy) begin
      n.wrdy  = 1'b0;
      n.wdata = i_wdata;
      n.wstrb = i_wstrb;
    end
    if (wr_do) begin
      n.bvalid = 1'b1;
      n.bresp  = GPEI_RESP_OKAY;
      case (wr_sel)
        GPEI_REG_OUTLVL: n.outlvl = gpei_merge(r.outlvl, r.wdata, r.wstrb);
        GPEI_REG_PINV:   n.pinv   = gpei_merge(r.pinv, r.wdata, r.wstrb);
        GPEI_REG_DIR:    n.dir    = gpei_merge(r.dir, r.wdata, r.wstrb);
        GPEI_REG_IEN:    n.ien    = gpei_merge(r.ien, r.wdata, r.wstrb);
        GPEI_REG_RISE:   n.rsel   = gpei_merge(r.rsel, r.wdata, r.wstrb);
        GPEI_REG_FALL:   n.fsel   = gpei_merge(r.fsel, r.wdata, r.wstrb);
        GPEI_REG_FILT:   n.fen    = gpei_merge(r.fen, r.wdata, r.wstrb);
        GPEI_REG_MASK:   n.mask   = gpei_merge(r.mask, r.wdata, r.wstrb);
        GPEI_REG_NONE:   n.bresp  = GPEI_RESP_SLVERR;
        default:         n.bresp  = GPEI_RESP_OKAY;
      endcase
    end
    if (r.bvalid && i_bready) begin
      n.bvalid = 1'b0;
      n.awrdy  = 1'b1;
      n.wrdy   = 1'b1;
    end
    // Read path: one read at a time, data captured at the address handshake.
    if (ar_hs) begin
      n.arrdy  = 1'b0;
      n.rvalid = 1'b1;
      n.rresp  = GPEI_RESP_OKAY;
      n.rdata  = 32'h0000_0000;
      case (rd_sel)
        GPEI_REG_STATE:  n.rdata[15:0] = state_v;
        GPEI_REG_OUTLVL: n.rdata[15:0] = r.outlvl;
        GPEI_REG_PINV:   n.rdata[15:0] = r.pinv;
        GPEI_REG_DIR:    n.rdata[15:0] = r.dir;
        GPEI_REG_IEN:    n.rdata[15:0] = r.ien;
        GPEI_REG_STATUS: n.rdata[15:0] = r.status;
        GPEI_REG_RISE:   n.rdata[15:0] = r.rsel;
        GPEI_REG_FALL:   n.rdata[15:0] = r.fsel;
        GPEI_REG_FILT:   n.rdata[15:0] = r.fen;
        GPEI_REG_MASK:   n.rdata[15:0] = r.mask;
        GPEI_REG_NONE:   n.rresp       = GPEI_RESP_SLVERR;
        default:         n.rdata       = 32'h0000_0000;
      endcase
    end
    if (r.rvalid && i_rready) begin
      n.rvalid = 1'b0;
      n.arrdy  = 1'b1;
    end
    n.irq_n   = ~|(n.status & n.mask);
    n.pin_out = n.outlvl;
    n.pin_oe  = ~n.dir;
  end

  // State register with constant reset values.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r         <= '0;
      r.outlvl  <= GPEI_RST_OUTLVL;
      r.pinv    <= GPEI_RST_PINV;
      r.dir     <= GPEI_RST_DIR;
      r.ien     <= GPEI_RST_IEN;
      r.rsel    <= GPEI_RST_RISE;
      r.fsel    <= GPEI_RST_FALL;
      r.fen     <= GPEI_RST_FILT;
      r.mask    <= GPEI_RST_MASK;
      r.awrdy   <= 1'b1;
      r.wrdy    <= 1'b1;
      r.arrdy   <= 1'b1;
      r.irq_n   <= 1'b1;
      r.pin_out <= GPEI_RST_OUTLVL;
      r.pin_oe  <= ~GPEI_RST_DIR;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register.
  assign o_awready = r.awrdy;
  assign o_wready  = r.wrdy;
  assign o_bresp   = r.bresp;
  assign o_bvalid  = r.bvalid;
  assign o_arready = r.arrdy;
  assign o_rdata   = r.rdata;
  assign o_rresp   = r.rresp;
  assign o_rvalid  = r.rvalid;
  assign o_pin_out = r.pin_out;
  assign o_pin_oe  = r.pin_oe;
  assign o_irq_n   = r.irq_n;

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_state_read;
    ar_hs && (rd_sel == GPEI_REG_STATE);
  endsequence

  sequence s_read_answer;
    r.rvalid && !$past(r.rvalid);
  endsequence

  a_no_irq_inactive: assert property (
    ((r.status & ~$past(r.status) & ~$past(active_v)) == 16'h0000))
    else $error("Status bit rose on a disabled or output pin.");

  a_read_clears: assert property (s_state_read |=> (r.status == $past(set_v)))
    else $error("Pin-state read did not clear the status.");

  a_revert_clears: assert property (
    (revert_v != 16'h0000) |=> ((r.status & $past(revert_v) & ~$past(set_v)) == 16'h0000))
    else $error("Return to the read level did not clear the status.");

  a_rise_only: assert property (
    ((r.status & ~$past(r.status) & $past(r.rsel & ~r.fsel) & ~$past(rise_v)) == 16'h0000))
    else $error("Rising-only pin flagged without a rising edge.");

  a_fall_only: assert property (
    ((r.status & ~$past(r.status) & $past(~r.rsel & r.fsel) & ~$past(fall_v)) == 16'h0000))
    else $error("Falling-only pin flagged without a falling edge.");

  a_any_edge_sets: assert property (
    ((rise_v | fall_v) & active_v & ((r.rsel & r.fsel) | (any_mode_v & (lvl_w ^ r.snap)))) != 16'h0000
    |=> (($past((rise_v | fall_v) & active_v & ((r.rsel & r.fsel) | (any_mode_v & (lvl_w ^ r.snap))))
         & ~r.status) == 16'h0000))
    else $error("Edge in any-edge mode did not set the status.");

  a_edge_sticky: assert property (
    ((~r.status & $past(r.status) & $past(r.rsel | r.fsel) & ~$past(swclr_v)) != 16'h0000)
    |-> $past(st_rd))
    else $error("Edge-mode status cleared without a pin-state read.");

  a_irq_output: assert property (
    ##1 (o_irq_n == !(|(r.status & r.mask))))
    else $error("Interrupt output disagrees with the status.");

  a_state_value: assert property (s_state_read ##1 s_read_answer |->
    (r.rdata[15:0] == $past(state_v)))
    else $error("Pin-state read returned a wrong value.");

endmodule

// ---- hw/gpei_pkg.sv ----
package gpei_pkg;

  // ==========================================================================
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] GPEI_OFF_STATE  = 8'h00;
  localparam logic [7:0] GPEI_OFF_OUTLVL = 8'h04;
  localparam logic [7:0] GPEI_OFF_PINV   = 8'h08;
  localparam logic [7:0] GPEI_OFF_DIR    = 8'h0C;
  localparam logic [7:0] GPEI_OFF_IEN    = 8'h10;
  localparam logic [7:0] GPEI_OFF_STATUS = 8'h14;
  localparam logic [7:0] GPEI_OFF_RISE   = 8'h18;
  localparam logic [7:0] GPEI_OFF_FALL   = 8'h1C;
  localparam logic [7:0] GPEI_OFF_FILT   = 8'h20;
  localparam logic [7:0] GPEI_OFF_CLEAR  = 8'h24;
  localparam logic [7:0] GPEI_OFF_MASK   = 8'h28;

  // ==========================================================================
  // Values after reset.
  localparam logic [15:0] GPEI_RST_OUTLVL = 16'hFFFF;
  localparam logic [15:0] GPEI_RST_PINV   = 16'h0000;
  localparam logic [15:0] GPEI_RST_DIR    = 16'hFFFF;
  localparam logic [15:0] GPEI_RST_IEN    = 16'h0000;
  localparam logic [15:0] GPEI_RST_RISE   = 16'h0000;
  localparam logic [15:0] GPEI_RST_FALL   = 16'h0000;
  localparam logic [15:0] GPEI_RST_FILT   = 16'hFFFF;
  localparam logic [15:0] GPEI_RST_MASK   = 16'hFFFF;

  // AXI response codes.
  localparam logic [1:0] GPEI_RESP_OKAY   = 2'h0;
  localparam logic [1:0] GPEI_RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Glitch filter timing: the new level must hold for more than the interval.
  localparam int unsigned GPEI_FILT_NS      = 1075;
  localparam int unsigned GPEI_CLK_PS       = 4000;
  localparam int unsigned GPEI_FILT_CYC_INT = (GPEI_FILT_NS * 1000 + GPEI_CLK_PS) / GPEI_CLK_PS;
  localparam logic [8:0]  GPEI_FILT_CYCLES  = GPEI_FILT_CYC_INT[8:0];

  // Register selector produced by the address decoder.
  typedef enum logic [3:0] {
    GPEI_REG_STATE  = 4'b0000,
    GPEI_REG_OUTLVL = 4'b0001,
    GPEI_REG_PINV   = 4'b0010,
    GPEI_REG_DIR    = 4'b0011,
    GPEI_REG_IEN    = 4'b0100,
    GPEI_REG_STATUS = 4'b0101,
    GPEI_REG_RISE   = 4'b0110,
    GPEI_REG_FALL   = 4'b0111,
    GPEI_REG_FILT   = 4'b1000,
    GPEI_REG_CLEAR  = 4'b1001,
    GPEI_REG_MASK   = 4'b1010,
    GPEI_REG_NONE   = 4'b1111
  } gpei_reg_e;

endpackage

// ---- hw/gpei_filter.sv ----
`timescale 1ns/10ps
module gpei_filter (
  input  wire logic i_core_clk, // Core clock.
  input  wire logic i_rst_n,    // Asynchronous reset, active low.
  input  wire logic i_pin,      // Pin level.
  input  wire logic i_filt_en,  // Glitch filter enable.
  output logic      o_raw,      // Synchronised pin level.
  output logic      o_lvl       // Qualified level used for edge detection.
);
  import gpei_pkg::*;

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       filt;
    logic [8:0] cnt;
  } gpei_flt_s;

  gpei_flt_s r;
  gpei_flt_s n;

  // ==========================================================================
  // Synchroniser and filter counter; a change that does not last restarts the count.
  always_comb begin
    n       = r;
    n.sync1 = i_pin;
    n.sync2 = r.sync1;
    if (!i_filt_en) begin
      n.filt = r.sync2;
      n.cnt  = 9'h000;
    end else if (r.sync2 == r.filt) begin
      n.cnt = 9'h000;
    end else if (r.cnt == GPEI_FILT_CYCLES - 9'h001) begin
      n.filt = r.sync2;
      n.cnt  = 9'h000;
    end else begin
      n.cnt = r.cnt + 9'h001;
    end
  end

  // State register.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_raw = r.sync2;
  assign o_lvl = r.filt;

  // A filtered level change needs the new level held for the whole interval.
  a_filter_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ($changed(r.filt) && $past(i_filt_en)) |-> ($past(r.cnt) == GPEI_FILT_CYCLES - 9'h001))
    else $error("Filtered level changed before the interval expired.");

endmodule

// ---- dv/gpei_pin_src.sv ----
`timescale 1ns/10ps
// ============================================================================
// External signal sources that stand on the expander's pins.
module gpei_pin_src (
  input  wire logic        i_core_clk, // Clock that the sources change after.
  input  wire logic [15:0] i_pin_out,  // Levels driven by the device.
  input  wire logic [15:0] i_pin_oe,   // Device drive enables, high while driven.
  output logic      [15:0] o_pin       // Resolved pin levels.
);
  logic [15:0] src_r = 16'h0000;

  // A pin that the device drives shows its level; the others show the source.
  assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & src_r);

  // Changes one source just after a rising edge.
  task automatic drive(input int idx, input logic v);
    @(posedge i_core_clk);
    src_r[idx] <= v;
  endtask
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
// ============================================================================
// Self-checking bench for the pin interrupt block.
module testbench;
  import gpei_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq_n;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] pin, pin_out, pin_oe;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cyc = 0;

  // Clock of 4 ns period.
  always #2 clk = ~clk;

  gpei_pin_src SRC (.i_core_clk(clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .o_pin(pin));

  gpei_top DUT (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_pin(pin),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_irq_n(irq_n)
  );

  // ==========================================================================
  // Comparison, report and bus tasks.
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Offers address and data together and holds each until it is taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (aw_ok && w_ok && bvalid === 1'b1) begin
        chk_val({30'h0, bresp}, {30'h0, er}, "write response");
        bready <= 1'b0;
        break;
      end
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
  endtask

  // Reads one word and compares data and response.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic ar_ok;
    ar_ok = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (ar_ok && rvalid === 1'b1) begin
        chk_val(rdata, exp, "read data");
        chk_val({30'h0, rresp}, {30'h0, er}, "read response");
        rready <= 1'b0;
        break;
      end
      if (!ar_ok && arready === 1'b1) begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
    end
  endtask

  task automatic cfg(input logic [15:0] ien, input logic [15:0] rise, input logic [15:0] fall,
                     input logic [15:0] filt);
    axi_wr(GPEI_OFF_IEN, {16'h0, ien}, GPEI_RESP_OKAY);
    axi_wr(GPEI_OFF_RISE, {16'h0, rise}, GPEI_RESP_OKAY);
    axi_wr(GPEI_OFF_FALL, {16'h0, fall}, GPEI_RESP_OKAY);
    axi_wr(GPEI_OFF_FILT, {16'h0, filt}, GPEI_RESP_OKAY);
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_reset;
    logic [7:0]  offs [6] = '{GPEI_OFF_OUTLVL, GPEI_OFF_PINV, GPEI_OFF_DIR, GPEI_OFF_IEN,
                              GPEI_OFF_FILT, GPEI_OFF_MASK};
    logic [15:0] vals [6] = '{GPEI_RST_OUTLVL, GPEI_RST_PINV, GPEI_RST_DIR, GPEI_RST_IEN,
                              GPEI_RST_FILT, GPEI_RST_MASK};
    chk_bit(irq_n, 1'b1, "irq after reset");
    chk_val({16'h0, pin_oe}, 32'h0, "all pins inputs after reset");
    for (int i = 0; i < 6; i++) begin
      rd_chk(offs[i], {16'h0, vals[i]}, GPEI_RESP_OKAY);
    end
    rd_chk(GPEI_OFF_RISE, {16'h0, GPEI_RST_RISE}, GPEI_RESP_OKAY);
    rd_chk(GPEI_OFF_FALL, {16'h0, GPEI_RST_FALL}, GPEI_RESP_OKAY);
    rd_chk(GPEI_OFF_STATUS, 32'h0, GPEI_RESP_OKAY);
    rd_chk(GPEI_OFF_CLEAR, 32'h0, GPEI_RESP_OKAY);
    rd_chk(8'h30, 32'h0, GPEI_RESP_SLVERR);
    rd_chk(8'h02, 32'h0, GPEI_RESP_SLVERR);
  endtask

  // Rising edge, then revert; expectations differ per edge-select mode.
  task automatic t_mode(input logic r, input logic f, input logic e_rise, input logic e_rev);
    cfg(16'h0001, {15'h0, r}, {15'h0, f}, 16'h0000);
    rd_chk(GPEI_OFF_STATE, 32'h0, GPEI_RESP_OKAY);
    SRC.drive(0, 1'b1);
    wait_cyc(8);
    rd_chk(GPEI_OFF_STATUS, {31'h0, e_rise}, GPEI_RESP_OKAY);
    chk_bit(irq_n, ~e_rise, "irq after rise");
    SRC.drive(0, 1'b0);
    wait_cyc(8);
    rd_chk(GPEI_OFF_STATUS, {31'h0, e_rev}, GPEI_RESP_OKAY);
    rd_chk(GPEI_OFF_STATE, 32'h0, GPEI_RESP_OKAY);
    rd_chk(GPEI_OFF_STATUS, 32'h0, GPEI_RESP_OKAY);
    chk_bit(irq_n, 1'b1, "irq released");
  endtask

  // Input pin with the interrupt enable at 0 stays silent.
  task automatic t_off;
    cfg(16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000);
    SRC.drive(3, 1'b1);
    wait_cyc(8);
    rd_chk(GPEI_OFF_STATUS, 32'h0, GPEI_RESP_OKAY);
    SRC.drive(3, 1'b0);
    wait_cyc(8);
    rd_chk(GPEI_OFF_STATUS, 32'h0, GPEI_RESP_OKAY);
    chk_bit(irq_n, 1'b1, "irq with enable off");
  endtask

  // A one-cycle bounce restarts the filter count.
  task automatic t_filter;
    cfg(16'h0001, 16'h0001, 16'h0000, 16'h0001);
    rd_chk(GPEI_OFF_STATE, 32'h0, GPEI_RESP_OKAY);
    SRC.drive(0, 1'b1);
    wait_cyc(200);
    SRC.drive(0, 1'b0);
    SRC.drive(0, 1'b1);
    wait_cyc(200);
    rd_chk(GPEI_OFF_STATUS, 32'h0, GPEI_RESP_OKAY);
    wait_cyc(100);
    rd_chk(GPEI_OFF_STATUS, 32'h1, GPEI_RESP_OKAY);
    rd_chk(GPEI_OFF_STATE, 32'h1, GPEI_RESP_OKAY);
    SRC.drive(0, 1'b0);
    wait_cyc(300);
    rd_chk(GPEI_OFF_STATUS, 32'h0, GPEI_RESP_OKAY);
  endtask

  // Output pin toggled by the device, plus an inverted input on pin 1.
  task automatic t_output;
    cfg(16'h0001, 16'h0001, 16'h0000, 16'h0000);
    axi_wr(GPEI_OFF_PINV, 32'h2, GPEI_RESP_OKAY);
    axi_wr(GPEI_OFF_OUTLVL, 32'hFFFE, GPEI_RESP_OKAY);
    axi_wr(GPEI_OFF_DIR, 32'hFFFE, GPEI_RESP_OKAY);
    wait_cyc(2);
    chk_val({16'h0, pin_oe}, 32'h1, "drive enable of output");
    chk_val({16'h0, pin_out}, 32'hFFFE, "output level");
    axi_wr(GPEI_OFF_OUTLVL, 32'hFFFF, GPEI_RESP_OKAY);
    wait_cyc(8);
    rd_chk(GPEI_OFF_STATUS, 32'h0, GPEI_RESP_OKAY);
    chk_bit(irq_n, 1'b1, "irq for output pin");
    rd_chk(GPEI_OFF_STATE, 32'h3, GPEI_RESP_OKAY);
    axi_wr(GPEI_OFF_DIR, 32'hFFFF, GPEI_RESP_OKAY);
    axi_wr(GPEI_OFF_PINV, 32'h0, GPEI_RESP_OKAY);
    wait_cyc(8);
    rd_chk(GPEI_OFF_STATE, 32'h0, GPEI_RESP_OKAY);
  endtask

  // Interrupt raised on pin 2, masked, unmasked and cleared.
  task automatic t_irq;
    cfg(16'h0004, 16'h0004, 16'h0000, 16'h0000);
    SRC.drive(2, 1'b1);
    wait_cyc(8);
    rd_chk(GPEI_OFF_STATUS, 32'h4, GPEI_RESP_OKAY);
    chk_bit(irq_n, 1'b0, "irq asserted");
    axi_wr(GPEI_OFF_MASK, 32'h0, GPEI_RESP_OKAY);
    wait_cyc(2);
    chk_bit(irq_n, 1'b1, "irq masked");
    axi_wr(GPEI_OFF_STATUS, 32'h0, GPEI_RESP_OKAY);
    axi_wr(8'h2C, 32'hFFFF, GPEI_RESP_SLVERR);
    axi_wr(GPEI_OFF_MASK, 32'hFFFF, GPEI_RESP_OKAY);
    wait_cyc(2);
    rd_chk(GPEI_OFF_STATUS, 32'h4, GPEI_RESP_OKAY);
    chk_bit(irq_n, 1'b0, "irq unmasked");
    axi_wr(GPEI_OFF_CLEAR, 32'h4, GPEI_RESP_OKAY);
    wait_cyc(2);
    rd_chk(GPEI_OFF_STATUS, 32'h0, GPEI_RESP_OKAY);
    chk_bit(irq_n, 1'b1, "irq after clear");
    SRC.drive(2, 1'b0);
    wait_cyc(8);
    rd_chk(GPEI_OFF_STATE, 32'h0, GPEI_RESP_OKAY);
  endtask

  // ==========================================================================
  // Watchdog that ends a hung run.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("MISMATCH t=%0t run did not finish", $time);
      report_and_stop();
    end
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_mode(1'b0, 1'b0, 1'b1, 1'b0);
    t_mode(1'b1, 1'b0, 1'b1, 1'b1);
    t_mode(1'b0, 1'b1, 1'b0, 1'b1);
    t_mode(1'b1, 1'b1, 1'b1, 1'b1);
    t_off();
    t_filter();
    t_output();
    t_irq();
    report_and_stop();
  end
endmodule
